// ==== core/dss_cfg_if.sv ====
// configuration and state carrier between register file and sequencer
`timescale 1ns/1ps
`default_nettype none

interface dss_cfg_if;
	logic [dss_pkg::CODE_W-1:0] next_state_code;
	logic                       arm;
	dss_pkg::dss_seq_e          seq_state;

	modport regs (output next_state_code, output arm, input seq_state);
	modport seq  (input next_state_code, input arm, output seq_state);
endinterface

`default_nettype wire

// ==== core/dss_nsel.sv ====
// per-channel next-state decode with priority resolution
`timescale 1ns/1ps
`default_nettype none

module dss_nsel #(
	parameter int N_CH = 4
) (
	// match events and selection code
	input  wire logic [N_CH-1:0]            i_match,
	input  wire logic [dss_pkg::CODE_W-1:0] i_code,
	// resolved transition
	output logic                            o_fire,
	output dss_pkg::dss_tgt_e               o_target
);

	// ------------------------------------------------------------------
	// decode of one channel's effect under a code
	// ------------------------------------------------------------------
	function automatic dss_pkg::dss_tgt_e chan_target(
		input logic [dss_pkg::CODE_W-1:0] code,
		input int                         ch
	);
		dss_pkg::dss_tgt_e t;
		t = dss_pkg::TGT_NONE;
		case (code)
			dss_pkg::SC_ANY_S2:    t = dss_pkg::TGT_S2;
			dss_pkg::SC_ANY_S3:    t = dss_pkg::TGT_S3;
			dss_pkg::SC_ANY_FIN:   t = dss_pkg::TGT_FIN;
			dss_pkg::SC_M2_S2:     if (ch == 2) t = dss_pkg::TGT_S2;
			dss_pkg::SC_M2_S3:     if (ch == 2) t = dss_pkg::TGT_S3;
			dss_pkg::SC_M2_FIN:    if (ch == 2) t = dss_pkg::TGT_FIN;
			dss_pkg::SC_M0S2_M1S3: begin
				if (ch == 0) t = dss_pkg::TGT_S2;
				if (ch == 1) t = dss_pkg::TGT_S3;
			end
			dss_pkg::SC_M1S3_M0F: begin
				if (ch == 1) t = dss_pkg::TGT_S3;
				if (ch == 0) t = dss_pkg::TGT_FIN;
			end
			dss_pkg::SC_M0S2_M2S3: begin
				if (ch == 0) t = dss_pkg::TGT_S2;
				if (ch == 2) t = dss_pkg::TGT_S3;
			end
			dss_pkg::SC_M2S3_M0F: begin
				if (ch == 2) t = dss_pkg::TGT_S3;
				if (ch == 0) t = dss_pkg::TGT_FIN;
			end
			dss_pkg::SC_M1S2_M3S3: begin
				if (ch == 1) t = dss_pkg::TGT_S2;
				if (ch == 3) t = dss_pkg::TGT_S3;
			end
			dss_pkg::SC_M3S3_M1F: begin
				if (ch == 3) t = dss_pkg::TGT_S3;
				if (ch == 1) t = dss_pkg::TGT_FIN;
			end
			dss_pkg::SC_LOW3_S2:   if (ch != 3) t = dss_pkg::TGT_S2;
			default:               t = dss_pkg::TGT_NONE; // reserved codes
		endcase
		return t;
	endfunction

	// ------------------------------------------------------------------
	// per-channel candidates
	// ------------------------------------------------------------------
	dss_pkg::dss_tgt_e cand [N_CH];

	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_chan
			assign cand[g] = i_match[g] ? chan_target(i_code, g) : dss_pkg::TGT_NONE;
		end
	endgenerate

	// ------------------------------------------------------------------
	// lowest channel wins, but a final-state candidate beats all
	// ------------------------------------------------------------------
	always_comb begin
		o_target = dss_pkg::TGT_NONE;
		for (int i = N_CH - 1; i >= 0; i--) begin
			if (cand[i] != dss_pkg::TGT_NONE) o_target = cand[i];
		end
		for (int i = 0; i < N_CH; i++) begin
			if (cand[i] == dss_pkg::TGT_FIN) o_target = dss_pkg::TGT_FIN;
		end
		o_fire = (o_target != dss_pkg::TGT_NONE);
	end

endmodule

`default_nettype wire

// ==== core/dss_pkg.sv ====
// constants, types and register map of the State1 next-state sequencer
package dss_pkg;

	// ------------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int IDX_W = 6;

	// ------------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_NEXT_SEL = 6'h27;
	localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h20;
	localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h21;

	// ------------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------------
	localparam int CODE_LSB       = 0;
	localparam int CODE_W         = 4;
	localparam int CTRL_ARM_BIT   = 0;
	localparam int CTRL_VIEW_LSB  = 1;
	localparam int VIEW_W         = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STATE_W        = 3;
	localparam int STAT_ARMED_BIT = 3;
	localparam logic [CODE_W-1:0] CODE_RST     = 4'h0;
	localparam logic [VIEW_W-1:0] VIEW_PRIMARY = 2'h0;
	localparam logic [VIEW_W-1:0] VIEW_RST     = 2'h0;

	// ------------------------------------------------------------------
	// next-state codes
	// ------------------------------------------------------------------
	localparam logic [CODE_W-1:0] SC_ANY_S2    = 4'h0;
	localparam logic [CODE_W-1:0] SC_ANY_S3    = 4'h1;
	localparam logic [CODE_W-1:0] SC_ANY_FIN   = 4'h2;
	localparam logic [CODE_W-1:0] SC_M2_S2     = 4'h3;
	localparam logic [CODE_W-1:0] SC_M2_S3     = 4'h4;
	localparam logic [CODE_W-1:0] SC_M2_FIN    = 4'h5;
	localparam logic [CODE_W-1:0] SC_M0S2_M1S3 = 4'h6;
	localparam logic [CODE_W-1:0] SC_M1S3_M0F  = 4'h7;
	localparam logic [CODE_W-1:0] SC_M0S2_M2S3 = 4'h8;
	localparam logic [CODE_W-1:0] SC_M2S3_M0F  = 4'h9;
	localparam logic [CODE_W-1:0] SC_M1S2_M3S3 = 4'ha;
	localparam logic [CODE_W-1:0] SC_M3S3_M1F  = 4'hb;
	localparam logic [CODE_W-1:0] SC_LOW3_S2   = 4'hc;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [STATE_W-1:0] {
		SEQ_IDLE,
		SEQ_STATE1,
		SEQ_STATE2,
		SEQ_STATE3,
		SEQ_FINAL
	} dss_seq_e;

	typedef enum logic [1:0] {
		TGT_NONE,
		TGT_S2,
		TGT_S3,
		TGT_FIN
	} dss_tgt_e;

endpackage

// ==== core/dss_regs.sv ====
// classic wishbone slave holding the sequencer registers
`timescale 1ns/1ps
`default_nettype none

module dss_regs (
	// clock, reset, enable
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_en,
	// wishbone slave
	input  wire logic                      i_cyc,
	input  wire logic                      i_stb,
	input  wire logic                      i_we,
	input  wire logic [dss_pkg::ADR_W-1:0] i_adr,
	input  wire logic [3:0]                i_sel,
	input  wire logic [dss_pkg::DAT_W-1:0] i_dat,
	output logic      [dss_pkg::DAT_W-1:0] o_dat,
	output logic                           o_ack,
	// to the sequencer
	dss_cfg_if.regs                        cfg
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic                        ack_ff;
	logic [dss_pkg::DAT_W-1:0]   dat_ff;
	logic [dss_pkg::CODE_W-1:0]  code_ff;
	logic                        arm_ff;
	logic [dss_pkg::VIEW_W-1:0]  view_ff;
	logic [dss_pkg::IDX_W-1:0]   idx;
	logic                        req;
	logic                        wr;
	logic [dss_pkg::DAT_W-1:0]   nxt_dat;

	// select slot only exists in the primary view
	function automatic logic sel_visible(
		input logic [dss_pkg::IDX_W-1:0]  a,
		input logic [dss_pkg::VIEW_W-1:0] v
	);
		return (a == dss_pkg::IDX_NEXT_SEL) && (v == dss_pkg::VIEW_PRIMARY);
	endfunction

	assign idx = i_adr[dss_pkg::ADR_W-1:2];
	assign req = i_cyc & i_stb & ~ack_ff;
	assign wr  = req & i_we & i_sel[0];

	// ------------------------------------------------------------------
	// ack one cycle after the strobe, dropped the cycle after
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) ack_ff <= 1'b0;
		else if (i_en) ack_ff <= req;
	end

	// ------------------------------------------------------------------
	// read mux, registered; unmapped reads return zero
	// ------------------------------------------------------------------
	always_comb begin
		nxt_dat = '0;
		if (sel_visible(idx, view_ff)) begin
			nxt_dat[dss_pkg::CODE_LSB +: dss_pkg::CODE_W] = code_ff; // readable anytime in the primary view
		end else if (idx == dss_pkg::IDX_CTRL) begin
			nxt_dat[dss_pkg::CTRL_ARM_BIT] = arm_ff;
			nxt_dat[dss_pkg::CTRL_VIEW_LSB +: dss_pkg::VIEW_W] = view_ff;
		end else if (idx == dss_pkg::IDX_STATUS) begin
			nxt_dat[dss_pkg::STAT_STATE_LSB +: dss_pkg::STATE_W] = cfg.seq_state;
			nxt_dat[dss_pkg::STAT_ARMED_BIT] = arm_ff;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) dat_ff <= '0;
		else if (i_en && req) dat_ff <= nxt_dat;
	end

	// ------------------------------------------------------------------
	// select code: write blocked while armed, so a running
	// sequence never sees its routing change underneath it
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) code_ff <= dss_pkg::CODE_RST;
		else if (i_en && wr && sel_visible(idx, view_ff) && !arm_ff) begin
			code_ff <= i_dat[dss_pkg::CODE_LSB +: dss_pkg::CODE_W];
		end
	end

	// control: arm and view select, writable anytime
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			arm_ff  <= 1'b0;
			view_ff <= dss_pkg::VIEW_RST;
		end else if (i_en && wr && idx == dss_pkg::IDX_CTRL) begin
			arm_ff  <= i_dat[dss_pkg::CTRL_ARM_BIT];
			view_ff <= i_dat[dss_pkg::CTRL_VIEW_LSB +: dss_pkg::VIEW_W];
		end
	end

	assign o_ack               = ack_ff;
	assign o_dat               = dat_ff;
	assign cfg.next_state_code = code_ff;
	assign cfg.arm             = arm_ff;

endmodule

`default_nettype wire

// ==== core/dss_top.sv ====
// top of the State1 next-state sequencer with its register slave
`timescale 1ns/1ps
`default_nettype none

module dss_top #(
	parameter int N_CH = 4
) (
	// clock, reset, enable
	input  wire logic                      I_MCLK,
	input  wire logic                      I_SYS_RST,
	input  wire logic                      I_CLK_EN,
	// wishbone slave
	input  wire logic                      I_WB_CYC,
	input  wire logic                      I_WB_STB,
	input  wire logic                      I_WB_WE,
	input  wire logic [dss_pkg::ADR_W-1:0] I_WB_ADR,
	input  wire logic [3:0]                I_WB_SEL,
	input  wire logic [dss_pkg::DAT_W-1:0] I_WB_DAT,
	output logic      [dss_pkg::DAT_W-1:0] O_WB_DAT,
	output logic                           O_WB_ACK,
	// comparator match channels, same clock
	input  wire logic [N_CH-1:0]           I_MATCH,
	// sequencer state
	output logic      [dss_pkg::STATE_W-1:0] O_SEQ_STATE,
	output logic                           O_ARMED
);

	// ------------------------------------------------------------------
	// internal signals
	// ------------------------------------------------------------------
	dss_cfg_if          cfg ();
	dss_pkg::dss_seq_e  state_ff;
	dss_pkg::dss_seq_e  nxt_state;
	dss_pkg::dss_tgt_e  target;
	logic               fire;

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	dss_regs u_regs (
		.i_clk (I_MCLK),
		.i_rst (I_SYS_RST),
		.i_en  (I_CLK_EN),
		.i_cyc (I_WB_CYC),
		.i_stb (I_WB_STB),
		.i_we  (I_WB_WE),
		.i_adr (I_WB_ADR),
		.i_sel (I_WB_SEL),
		.i_dat (I_WB_DAT),
		.o_dat (O_WB_DAT),
		.o_ack (O_WB_ACK),
		.cfg   (cfg.regs)
	);

	// ------------------------------------------------------------------
	// match decode; matches assumed already gated by comparator enables
	// ------------------------------------------------------------------
	dss_nsel #(
		.N_CH (N_CH)
	) u_nsel (
		.i_match  (I_MATCH),
		.i_code   (cfg.next_state_code),
		.o_fire   (fire),
		.o_target (target)
	);

	// ------------------------------------------------------------------
	// sequencer: later states only wait for disarm here
	// ------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			dss_pkg::SEQ_IDLE: begin
				if (cfg.arm) nxt_state = dss_pkg::SEQ_STATE1;
			end
			dss_pkg::SEQ_STATE1: begin
				if (!cfg.arm) begin
					nxt_state = dss_pkg::SEQ_IDLE;
				end else if (fire) begin
					case (target)
						dss_pkg::TGT_S2:  nxt_state = dss_pkg::SEQ_STATE2;
						dss_pkg::TGT_S3:  nxt_state = dss_pkg::SEQ_STATE3;
						dss_pkg::TGT_FIN: nxt_state = dss_pkg::SEQ_FINAL;
						default:          nxt_state = dss_pkg::SEQ_STATE1;
					endcase
				end
			end
			dss_pkg::SEQ_STATE2,
			dss_pkg::SEQ_STATE3,
			dss_pkg::SEQ_FINAL: begin
				if (!cfg.arm) nxt_state = dss_pkg::SEQ_IDLE;
			end
			default: nxt_state = dss_pkg::SEQ_IDLE;
		endcase
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) state_ff <= dss_pkg::SEQ_IDLE;
		else if (I_CLK_EN) state_ff <= nxt_state;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign cfg.seq_state = state_ff;
	assign O_SEQ_STATE   = state_ff;
	assign O_ARMED       = cfg.arm;

endmodule

`default_nettype wire

// ==== verification/dss_cmp_model.sv ====
// comparator match source feeding the sequencer
`timescale 1ns/1ps
`default_nettype none

module dss_cmp_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// command from the bench
	input  wire logic       i_req,
	input  wire logic [3:0] i_hits,
	input  wire logic [3:0] i_en,
	input  wire logic [3:0] i_dly,
	// match channels
	output logic      [3:0] o_match
);
	logic [3:0] hold_ff;
	logic [3:0] cnt_ff;
	logic       act_ff;

	// channels stand for opcode-address matches only, never the vector range
	// one-cycle match pulse after a chosen delay, prompt or slow
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_match <= 4'h0;
			act_ff  <= 1'b0;
		end else begin
			o_match <= 4'h0;
			if (i_req) begin
				hold_ff <= i_hits;
				cnt_ff  <= i_dly;
				act_ff  <= 1'b1;
			end else if (act_ff) begin
				if (cnt_ff == 4'h0) begin
					o_match <= hold_ff & i_en;
					act_ff  <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
			end
		end
	end
endmodule

`default_nettype wire

// ==== verification/dss_props.sv ====
// concurrent checks on the ports of the sequencer top
`timescale 1ns/1ps
`default_nettype none

module dss_props #(
	parameter int N_CH = 4
) (
	// clock, reset, enable
	input wire logic                        I_MCLK,
	input wire logic                        I_SYS_RST,
	input wire logic                        I_CLK_EN,
	// wishbone slave
	input wire logic                        I_WB_CYC,
	input wire logic                        I_WB_STB,
	input wire logic                        I_WB_WE,
	input wire logic [dss_pkg::ADR_W-1:0]   I_WB_ADR,
	input wire logic [3:0]                  I_WB_SEL,
	input wire logic [dss_pkg::DAT_W-1:0]   I_WB_DAT,
	input wire logic [dss_pkg::DAT_W-1:0]   O_WB_DAT,
	input wire logic                        O_WB_ACK,
	// matches and state
	input wire logic [N_CH-1:0]             I_MATCH,
	input wire logic [dss_pkg::STATE_W-1:0] O_SEQ_STATE,
	input wire logic                        O_ARMED
);
	// ------------------------------------------------------------------
	// shared request terms
	// ------------------------------------------------------------------
	// frozen cycles are not judged, the enable stalls everything
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST || !I_CLK_EN);
	wire logic take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	wire logic [5:0] idx = I_WB_ADR[7:2];

	a_ack_pulse_once: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack stayed high");
	a_ack_next_cycle: assert property (take |=> O_WB_ACK)
		else $error("ack late");
	a_unmapped_reads_zero: assert property (take && !I_WB_WE &&
		!(idx inside {6'h20, 6'h21, 6'h27}) |=> O_WB_DAT == 32'h0)
		else $error("unmapped read not zero");
	a_status_read_val: assert property (take && !I_WB_WE && idx == 6'h21
		|=> O_WB_DAT[3:0] == {$past(O_ARMED), $past(O_SEQ_STATE)})
		else $error("status read wrong");
	a_arm_write_sets: assert property (take && I_WB_WE && idx == 6'h20
		&& I_WB_SEL[0] && I_WB_DAT[0] |=> O_ARMED)
		else $error("arm write lost");
	a_disarm_goes_idle: assert property (!O_ARMED |=> O_SEQ_STATE == 3'h0)
		else $error("state not idle while disarmed");
	a_idle_to_first: assert property (O_ARMED && O_SEQ_STATE == 3'h0
		|=> O_SEQ_STATE == 3'h1)
		else $error("armed idle did not enter state1");
	a_first_needs_match: assert property (O_ARMED && O_SEQ_STATE == 3'h1
		&& I_MATCH == '0 |=> O_SEQ_STATE == 3'h1 || !O_ARMED)
		else $error("state1 left with no match");
	a_entry_from_first: assert property ($changed(O_SEQ_STATE)
		&& O_SEQ_STATE inside {3'h2, 3'h3, 3'h4}
		|-> $past(O_SEQ_STATE) == 3'h1 && $past(I_MATCH) != '0)
		else $error("target entered without cause");
	a_target_holds: assert property (O_ARMED && O_SEQ_STATE inside {3'h2, 3'h3, 3'h4}
		|=> $stable(O_SEQ_STATE) || !O_ARMED)
		else $error("target state moved");

	c_final_hit: cover property (O_SEQ_STATE == 3'h1 ##1 O_SEQ_STATE == 3'h4);
	c_state2_hit: cover property (O_SEQ_STATE == 3'h1 ##1 O_SEQ_STATE == 3'h2);
	c_read_ack: cover property (take && !I_WB_WE ##1 O_WB_ACK);
endmodule

bind dss_top dss_props #(.N_CH(N_CH)) dss_props_inst (
	.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CLK_EN(I_CLK_EN),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
	.I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
	.O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_MATCH(I_MATCH),
	.O_SEQ_STATE(O_SEQ_STATE), .O_ARMED(O_ARMED));

`default_nettype wire

// ==== verification/dss_top_test.sv ====
// register-level testbench of the State1 next-state sequencer
`timescale 1ns/1ps
`default_nettype none

module dss_top_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        req = 1'b0;
	logic [3:0]  hits = 4'h0;
	logic [3:0]  dly = 4'h0;
	logic        en = 1'b1;
	logic [3:0]  sel = 4'hf;
	logic [3:0]  sel_req = 4'hf;
	logic [3:0]  cmp_en = 4'hf;
	logic [3:0]  match;
	logic [2:0]  state;
	logic        armed;
	logic [31:0] q;
	int          error_cnt = 0;
	int          compares = 0;
	// code, hits, expected state
	logic [11:0] cases[20] = '{12'h012, 12'h113, 12'h284,
		12'h311, 12'h342, 12'h443, 12'h544, 12'h623, 12'h641,
		12'h734, 12'h852, 12'h954, 12'ha83, 12'haa2, 12'hba4,
		12'hc81, 12'hce2, 12'hdf1, 12'hef1, 12'hff1};

	dss_top dss_top_inst (
		.I_MCLK(clk), .I_SYS_RST(rst), .I_CLK_EN(en), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
		.I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_MATCH(match),
		.O_SEQ_STATE(state), .O_ARMED(armed));
	dss_cmp_model dss_cmp_model_inst (
		.i_clk(clk), .i_rst(rst), .i_req(req), .i_hits(hits),
		.i_en(cmp_en), .i_dly(dly), .o_match(match));

	initial begin
		forever #20 clk = ~clk;
	end

	task automatic conclude();
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic cycle; request held until ack is sampled, only the watchdog ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= sel_req;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic fire(input logic [3:0] h, input logic [3:0] d);
		@(posedge clk);
		req  <= 1'b1;
		hits <= h;
		dly  <= d;
		@(posedge clk);
		req <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 8'h80, 32'h0); chk(q, 32'h0);
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'h0);
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h0);
		foreach (cases[i]) begin
			wb(1'b1, 8'h80, 32'h0);
			wb(1'b1, 8'h9c, {28'h0, cases[i][11:8]});
			wb(1'b1, 8'h80, 32'h1);
			fire(cases[i][7:4], (i % 2 == 1) ? 4'h3 : 4'h0);
			wb(1'b0, 8'h84, 32'h0); chk(q, {28'h0, 1'b1, cases[i][2:0]});
		end
		// state2 ignores further matches, select locked while armed
		wb(1'b1, 8'h80, 32'h0);
		wb(1'b1, 8'h9c, 32'h0);
		wb(1'b1, 8'h80, 32'h1);
		fire(4'h1, 4'h0);
		fire(4'hf, 4'h1);
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'ha);
		wb(1'b1, 8'h9c, 32'h5);
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h0);
		wb(1'b1, 8'h80, 32'h0);
		fire(4'hf, 4'h0);
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'h0);
		// alternate register view hides the select register
		wb(1'b1, 8'h9c, 32'h7);
		wb(1'b1, 8'h80, 32'h2);
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h0);
		wb(1'b1, 8'h9c, 32'h3);
		wb(1'b1, 8'h80, 32'h0);
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h7);
		wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
		// byte lane 0 off: write ignored; a mid-run reset then clears the code
		sel_req = 4'he;
		wb(1'b1, 8'h9c, 32'h2);
		sel_req = 4'hf;
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h7);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 8'h9c, 32'h0); chk(q, 32'h0);
		wb(1'b0, 8'h80, 32'h0); chk(q, 32'h0);
		// disabled comparator and frozen clock enable both leave State1 alone
		wb(1'b1, 8'h80, 32'h1);
		cmp_en <= 4'he;
		fire(4'h1, 4'h0);
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'h9);
		cmp_en <= 4'hf;
		en <= 1'b0;
		fire(4'h1, 4'h0);
		en <= 1'b1;
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'h9);
		fire(4'h1, 4'h0);
		wb(1'b0, 8'h84, 32'h0); chk(q, 32'ha);
		conclude();
	end
endmodule

`default_nettype wire
